// ---- bench/can_ctrl_model.sv ----
// Behavioural controller driving mode, transmit and mask pins
`timescale 1ns/1ps
module can_ctrl_model (
    // Clock and fault feedback
    input wire clock_in,
    input wire fault_indicator_n,
    // Pins towards the transceiver
    output logic [4:0] mode_request_out,
    output logic txd_out,
    output logic mask_out
);
    // ----------------------------------------------------------------
    // Pin tasks
    // ----------------------------------------------------------------
    // Idle levels: standby, recessive, mask pulled low
    initial begin
        mode_request_out = 5'h04;
        txd_out = 1'h1;
        mask_out = 1'h0;
    end
    // Mode passes two flops, so allow four edges
    task set_mode(input logic [4:0] m);
        @(posedge clock_in);
        mode_request_out <= m;
        repeat (4) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    // Each edge one bit long, back to recessive
    task tx_falls(input int n);
        repeat (n) begin
            @(posedge clock_in);
            txd_out <= 1'h0;
            @(posedge clock_in);
            txd_out <= 1'h1;
        end
        repeat (2) @(negedge clock_in);
    endtask
    // Fault must be idle first, else its low is no acknowledge
    task set_mask(input logic v);
        int n;
        n = 0;
        while (fault_indicator_n !== 1'h1 && n < 8) begin
            @(posedge clock_in);
            n++;
        end
        @(posedge clock_in);
        mask_out <= v;
        repeat (20) @(negedge clock_in);
    endtask
endmodule

// ---- bench/status_mask_monitor.sv ----
// Port-level assertions for the status flags and power-enable mask block
`timescale 1ns/1ps
`include "status_mask_regs.vh"
module status_mask_monitor (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Bus signals watched
    input wire psel_in,
    input wire penable_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // Pin outputs watched
    input wire power_enable_output,
    input wire power_enable_oe_out,
    input wire fault_indicator_n,
    input wire fault_oe_out,
    input wire rxd_wake_n_out,
    input wire [4:0] mode_out
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Single clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_pready;
        psel_in && !penable_in |=> pready_out;
    endproperty
    a_pready: assert property (p_pready) else $error("no answer after setup");
    property p_slverr;
        pslverr_out |-> pready_out;
    endproperty
    a_slverr: assert property (p_slverr) else $error("error outside access");
    property p_rdzero;
        !pready_out |-> prdata_out == 32'h0;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("read data not idle");
    // Second sleep cycle: both pin enables switch on the same edge as mode_out, so already off
    property p_sleep_float;
        (mode_out == `MODE_SLEEP)[*2] |-> !power_enable_oe_out && !fault_oe_out;
    endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("pin driven in sleep");
    property p_pe_on;
        (mode_out != `MODE_SLEEP)[*2] |-> power_enable_oe_out;
    endproperty
    a_pe_on: assert property (p_pe_on) else $error("power enable floats awake");
    property p_rxd;
        !rxd_wake_n_out |-> mode_out == `MODE_STANDBY;
    endproperty
    a_rxd: assert property (p_rxd) else $error("wake shown outside standby");
    property p_mask_silent;
        $fell(power_enable_output) |-> mode_out inside {`MODE_SILENT, `MODE_SLEEP};
    endproperty
    a_mask_silent: assert property (p_mask_silent) else $error("mask outside silent");
    property p_gosleep;
        (mode_out == `MODE_GO_SLEEP)[*2] |-> fault_indicator_n;
    endproperty
    a_gosleep: assert property (p_gosleep) else $error("fault in go-to-sleep");
endmodule
bind transceiver_status_and_power_mask status_mask_monitor mon_u (
    .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .power_enable_output(power_enable_output),
    .power_enable_oe_out(power_enable_oe_out), .fault_indicator_n(fault_indicator_n),
    .fault_oe_out(fault_oe_out), .rxd_wake_n_out(rxd_wake_n_out), .mode_out(mode_out)
);

// ---- bench/transceiver_status_and_power_mask_bench.sv ----
// Self-checking bench for the status flags and power-enable mask block
`timescale 1ns/1ps
`include "status_mask_regs.vh"
module transceiver_status_and_power_mask_bench;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clock_in, rst_in, psel_in, penable_in, pwrite_in, err, txd, mask;
    logic wake_in, remote_wake_in, battery_low_in, core_low_in, logic_low_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, rd;
    logic [4:0] mode_req;
    wire [31:0] prdata_out;
    wire [4:0] mode_out;
    wire pready_out, pslverr_out, pe_out, pe_oe, fault_n, fault_oe, rxd_n;
    int n_errors, comparisons;
    transceiver_status_and_power_mask #(.UV_CYCLES(20)) dut_u (
        .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .mode_request_in(mode_req), .txd_in(txd),
        .power_enable_mask_input(mask), .wake_in(wake_in),
        .remote_wake_in(remote_wake_in), .battery_low_in(battery_low_in),
        .core_low_in(core_low_in), .logic_low_in(logic_low_in),
        .power_enable_output(pe_out), .power_enable_oe_out(pe_oe),
        .fault_indicator_n(fault_n), .fault_oe_out(fault_oe),
        .rxd_wake_n_out(rxd_n), .mode_out(mode_out));
    can_ctrl_model pm_u (.clock_in(clock_in), .fault_indicator_n(fault_n),
        .mode_request_out(mode_req), .txd_out(txd), .mask_out(mask));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    initial begin
        clock_in = 1'h0;
        forever #2 clock_in = ~clock_in;
    end
    // Holds the request until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in <= 1'h1;
        penable_in <= 1'h0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clock_in);
        penable_in <= 1'h1;
        // Sample edge by edge; data is taken at the edge pready is seen
        @(posedge clock_in);
        while (pready_out !== 1'h1 && n < 16) begin
            @(posedge clock_in);
            n++;
        end
        if (n == 16) n_errors++;
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task pulse(input int which);
        @(posedge clock_in);
        if (which == 0) wake_in <= 1'h1;
        else remote_wake_in <= 1'h1;
        @(posedge clock_in);
        remote_wake_in <= 1'h0;
    endtask
    // Run is a few hundred cycles; this is far beyond it
    initial begin
        #80000;
        n_errors++;
        results();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 48'h800000000000;
        {wake_in, remote_wake_in, battery_low_in, core_low_in, logic_low_in} = 5'h0;
        n_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'h0;
        repeat (3) @(negedge clock_in);
        chk(rxd_n, 1'h0);
        chk(fault_n, 1'h0);
        chk(pe_out, 1'h1);
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd & 32'h7F, 32'h0F);
        // Filter limit shortened so the mask latches in a few cycles
        apb(1'h0, `CTRL_OFFSET, 32'h0);
        chk(rd, 32'h9C4);
        apb(1'h1, `CTRL_OFFSET, 32'h5);
        apb(1'h0, `CTRL_OFFSET, 32'h0);
        chk(rd, 32'h5);
        apb(1'h0, 12'h00C, 32'h0);
        chk({err, rd}, 33'h100000000);
        pm_u.set_mode(`MODE_GO_SLEEP);
        chk(mode_out, `MODE_STANDBY);
        pm_u.set_mode(`MODE_NORMAL);
        chk(fault_n, 1'h0);
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd & 32'h3, 32'h0);
        pm_u.tx_falls(3);
        chk(fault_n, 1'h0);
        pm_u.tx_falls(1);
        chk(fault_n, 1'h1);
        pm_u.set_mode(`MODE_SILENT);
        pm_u.set_mask(1'h1);
        chk({pe_out, fault_n}, 2'h0);
        pm_u.set_mode(`MODE_STANDBY);
        chk({pe_out, fault_n}, 2'h1);
        pm_u.set_mode(`MODE_GO_SLEEP);
        pm_u.set_mode(`MODE_SLEEP);
        chk({pe_oe, fault_oe}, 2'h0);
        pulse(0);
        pulse(1);
        pm_u.set_mode(`MODE_STANDBY);
        chk(rxd_n, 1'h0);
        pm_u.set_mode(`MODE_SILENT);
        chk(fault_n, 1'h1);
        pm_u.set_mask(1'h0);
        chk({pe_out, fault_n}, 2'h2);
        pm_u.set_mode(`MODE_NORMAL);
        chk(fault_n, 1'h0);
        // Remote wake, then a lasting supply dip drops the request
        pm_u.set_mode(`MODE_SLEEP);
        pulse(1);
        pm_u.set_mode(`MODE_STANDBY);
        chk(rxd_n, 1'h0);
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd & 32'hE, 32'h6);
        @(posedge clock_in);
        {core_low_in, logic_low_in} <= 2'h3;
        repeat (30) @(posedge clock_in);
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd & 32'h40, 32'h40);
        {core_low_in, logic_low_in} <= 2'h0;
        repeat (2) @(negedge clock_in);
        chk(rxd_n, 1'h1);
        pm_u.set_mode(`MODE_NORMAL);
        chk(fault_n, 1'h1);
        // Battery loss discards a latched mask outside silent mode
        pm_u.set_mode(`MODE_SILENT);
        pm_u.set_mask(1'h1);
        pm_u.set_mode(`MODE_NORMAL);
        chk(pe_out, 1'h0);
        @(posedge clock_in);
        battery_low_in <= 1'h1;
        repeat (2) @(posedge clock_in);
        battery_low_in <= 1'h0;
        repeat (3) @(negedge clock_in);
        chk(pe_out, 1'h1);
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd & 32'h3F, 32'h0F);
        // Logic supply dip alone also drops wake request and source
        logic_low_in <= 1'h1;
        repeat (30) @(posedge clock_in);
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        chk(rd & 32'h47, 32'h01);
        results();
    end
endmodule

// ---- hdl/mask_filter.v ----
// Level filter for the power-enable mask input
`timescale 1ns/1ps
module mask_filter #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Filter input and qualifier
    input wire level_in,
    input wire enable_in,
    input wire [WIDTH-1:0] limit_in,
    // Filtered results
    output reg high_seen_out,
    output reg low_seen_out
);

reg [WIDTH-1:0] count_reg;
reg level_prev_reg;

// Count restarts on any level change or when qualifier drops
always @(posedge clock_in) begin
    if (rst_in) begin
        count_reg <= {WIDTH{1'b0}};
        level_prev_reg <= 1'b0;
        high_seen_out <= 1'b0;
        low_seen_out <= 1'b0;
    end else begin
        level_prev_reg <= level_in;
        if (!enable_in || (level_in != level_prev_reg)) begin
            count_reg <= {WIDTH{1'b0}};
            high_seen_out <= 1'b0;
            low_seen_out <= 1'b0;
        end else if (count_reg < limit_in) begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            high_seen_out <= 1'b0;
            low_seen_out <= 1'b0;
        end else begin
            // Held strictly longer than the limit
            high_seen_out <= level_in;
            low_seen_out <= ~level_in;
        end
    end
end

endmodule

// ---- hdl/transceiver_status_and_power_mask.v ----
// Status flags, fault indicator and power-enable masking of a CAN FD transceiver
//
// How it works
// - Mask input held high past filter time in silent mode disables power enable.
// - Mask input held low past filter time in silent mode re-enables it.
// - Latched mask survives core and logic supply loss and all mode changes.
// - Battery undervoltage drops the mask; power enable defaults on after cold start.
// - Any mask change sets change flag, pulling fault low in silent mode.
// - Entering normal, standby, go-to-sleep or sleep clears the change flag.
// - Power enable driven in all modes but sleep, where it floats.
// - Either edge of the wake input is a local wake event.
// - Fault output is the OR of active indications; wake also on receive pin.
// - Cold start flag shows on entering silent from standby/sleep; normal clears it.
// - Cold start sets wake request, local wake source and cold start flags.
// - Wake request shows in standby; cleared by normal or persistent undervoltage.
// - Wake request set only in low-power modes; restarts undervoltage timers.
// - In normal mode fault shows wake source: low local, high remote.
// - Wake source clears on four transmit falls, leaving normal, or undervoltage.
// - Core supply low flag is internal; clears on recovery or wake request.
// - Fault output floats in sleep mode.
// - Wake source keeps the first recorded source until cleared.
// - Go-to-sleep is refused while wake request is set.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "status_mask_regs.vh"
module transceiver_status_and_power_mask #(
    parameter UV_CYCLES = `UV_FILTER_CYCLES
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Controller pins and mode request
    input wire [4:0] mode_request_in,
    input wire txd_in,
    input wire power_enable_mask_input,
    // Wake sources and supply monitors
    input wire wake_in,
    input wire remote_wake_in,
    input wire battery_low_in,
    input wire core_low_in,
    input wire logic_low_in,
    // Outputs to pins
    output reg power_enable_output,
    output reg power_enable_oe_out,
    output reg fault_indicator_n,
    output reg fault_oe_out,
    output reg rxd_wake_n_out,
    output reg [4:0] mode_out
);

localparam [31:0] UV_CYCLES_W = UV_CYCLES;
localparam [15:0] UV_LIMIT = UV_CYCLES_W[15:0];
localparam [31:0] MASK_CYCLES_W = `MASK_FILTER_CYCLES;
localparam [15:0] MASK_LIMIT_RST = MASK_CYCLES_W[15:0];

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [4:0] mode_reg;
reg [4:0] mode_prev_reg;
reg mask_latched_reg;
reg mask_change_flag;
reg cold_start_flag;
reg wake_request_flag;
reg wake_source_flag;
reg wake_src_local_reg;
reg core_supply_low_flag;
reg core_low_prev_reg;
reg silent_from_low_reg;
reg wake_prev_reg;
reg txd_prev_reg;
reg [2:0] txd_edges_reg;
reg [15:0] mask_limit_reg;
wire mask_high_seen;
wire mask_low_seen;
wire core_uv_expired;
wire logic_uv_expired;

// ----------------------------------------------------------------
// Decoded conditions
// ----------------------------------------------------------------
wire cold = rst_in | battery_low_in;
wire changed = (mode_reg != mode_prev_reg);
wire in_normal = (mode_reg == `MODE_NORMAL);
wire in_silent = (mode_reg == `MODE_SILENT);
wire in_standby = (mode_reg == `MODE_STANDBY);
wire in_sleep = (mode_reg == `MODE_SLEEP);
wire low_power = in_standby | in_sleep | (mode_reg == `MODE_GO_SLEEP);
wire enter_normal = changed & in_normal;
wire enter_clear_modes = changed & ~in_silent; // Any entry other than silent
wire leave_normal = changed & (mode_prev_reg == `MODE_NORMAL);
wire local_rouse_event = wake_in ^ wake_prev_reg;
wire wake_event = local_rouse_event | remote_wake_in;
wire wake_set = wake_event & low_power;
wire uv_expired = core_uv_expired | logic_uv_expired;
wire txd_fall = txd_prev_reg & ~txd_in; // Recessive to dominant
// Filter result lags one edge, so re-qualify with silent mode
wire mask_set = mask_high_seen & ~mask_latched_reg & in_silent;
wire mask_clear = mask_low_seen & mask_latched_reg & in_silent;

// ----------------------------------------------------------------
// Submodules
// ----------------------------------------------------------------
mask_filter #(
    .WIDTH(`CTRL_WIDTH)
) u_mask_filter (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .level_in(power_enable_mask_input),
    .enable_in(in_silent),
    .limit_in(mask_limit_reg),
    .high_seen_out(mask_high_seen),
    .low_seen_out(mask_low_seen)
);

// Wake request restarts both undervoltage timers
uv_filter #(
    .WIDTH(16),
    .LIMIT(UV_LIMIT)
) u_core_uv (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .low_in(core_low_in),
    .restart_in(wake_set),
    .expired_out(core_uv_expired)
);

uv_filter #(
    .WIDTH(16),
    .LIMIT(UV_LIMIT)
) u_logic_uv (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .low_in(logic_low_in),
    .restart_in(wake_set),
    .expired_out(logic_uv_expired)
);

// ----------------------------------------------------------------
// Mode tracking; go-to-sleep is held off by a pending wake
// ----------------------------------------------------------------
always @(posedge clock_in) begin
    if (rst_in) begin
        mode_reg <= `MODE_RESET;
        mode_prev_reg <= `MODE_RESET;
    end else begin
        mode_prev_reg <= mode_reg;
        case (mode_request_in)
            `MODE_NORMAL, `MODE_SILENT, `MODE_STANDBY, `MODE_SLEEP: begin
                mode_reg <= mode_request_in;
            end
            `MODE_GO_SLEEP: begin
                if (!wake_request_flag) begin
                    mode_reg <= mode_request_in;
                end
            end
            default: begin
                mode_reg <= mode_reg; // Illegal code keeps the mode
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Mask latch; only battery loss or reset forgets it
// ----------------------------------------------------------------
always @(posedge clock_in) begin
    if (cold) begin
        mask_latched_reg <= 1'b0;
    end else if (mask_set) begin
        mask_latched_reg <= 1'b1;
    end else if (mask_clear) begin
        mask_latched_reg <= 1'b0;
    end
end

// Mask change flag; a new change wins over a mode-entry clear
always @(posedge clock_in) begin
    if (cold) begin
        mask_change_flag <= 1'b0;
    end else if (mask_set | mask_clear) begin
        mask_change_flag <= 1'b1;
    end else if (enter_clear_modes) begin
        mask_change_flag <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Cold start, wake request and wake source
// ----------------------------------------------------------------
always @(posedge clock_in) begin
    if (cold) begin
        cold_start_flag <= 1'b1;
        wake_request_flag <= 1'b1;
        wake_source_flag <= 1'b1;
        wake_src_local_reg <= 1'b1;
        silent_from_low_reg <= 1'b0;
    end else begin
        if (enter_normal) begin
            cold_start_flag <= 1'b0;
        end
        // Latched while silent was entered from standby or sleep
        if (changed) begin
            silent_from_low_reg <= in_silent &
                ((mode_prev_reg == `MODE_STANDBY) | (mode_prev_reg == `MODE_SLEEP));
        end
        if (wake_set) begin
            wake_request_flag <= 1'b1;
        end else if (enter_normal | uv_expired) begin
            wake_request_flag <= 1'b0;
        end
        // First source sticks until the flag is cleared
        if (wake_set & ~wake_source_flag) begin
            wake_source_flag <= 1'b1;
            wake_src_local_reg <= local_rouse_event;
        end else if (leave_normal | uv_expired |
                     (in_normal & txd_fall & (txd_edges_reg == `TXD_EDGES_TO_CLEAR - 3'h1))) begin
            wake_source_flag <= 1'b0;
        end
    end
end

// Transmit edge counter for wake source clearing
always @(posedge clock_in) begin
    if (cold || !in_normal || !wake_source_flag) begin
        txd_edges_reg <= 3'h0;
    end else if (txd_fall) begin
        txd_edges_reg <= txd_edges_reg + 3'h1;
    end
end

// Edge history of wake, transmit and core monitor inputs
always @(posedge clock_in) begin
    if (rst_in) begin
        wake_prev_reg <= 1'b0;
        txd_prev_reg <= 1'b1;
        core_low_prev_reg <= 1'b0;
    end else begin
        wake_prev_reg <= wake_in;
        txd_prev_reg <= txd_in;
        core_low_prev_reg <= core_low_in;
    end
end

// Core supply low flag; internal only, new fall wins over clear
always @(posedge clock_in) begin
    if (cold) begin
        core_supply_low_flag <= 1'b0;
    end else if (core_low_in & ~core_low_prev_reg) begin
        core_supply_low_flag <= 1'b1;
    end else if (~core_low_in | wake_set) begin
        core_supply_low_flag <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Pin outputs; faults are ORed per mode
// ----------------------------------------------------------------
reg fault_any;
always @* begin
    fault_any = 1'b0;
    if (in_silent) begin
        fault_any = mask_change_flag | (cold_start_flag & silent_from_low_reg);
    end else if (in_standby) begin
        fault_any = wake_request_flag;
    end else if (in_normal) begin
        fault_any = wake_source_flag & wake_src_local_reg;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        power_enable_output <= 1'b1;
        power_enable_oe_out <= 1'b1;
        fault_indicator_n <= 1'b1;
        fault_oe_out <= 1'b1;
        rxd_wake_n_out <= 1'b1;
        mode_out <= `MODE_RESET;
    end else begin
        power_enable_oe_out <= ~in_sleep;
        power_enable_output <= ~in_sleep & ~mask_latched_reg;
        fault_oe_out <= ~in_sleep;
        fault_indicator_n <= ~fault_any;
        rxd_wake_n_out <= ~(in_standby & wake_request_flag);
        mode_out <= mode_reg;
    end
end

// ----------------------------------------------------------------
// APB slave: answer one cycle after setup, no wait states
// ----------------------------------------------------------------
wire apb_setup = psel_in & ~penable_in;
wire apb_write = psel_in & penable_in & pready_out & pwrite_in;
wire hit_ctrl = (paddr_in == `CTRL_OFFSET);
wire hit_any = (paddr_in == `STATUS_OFFSET) | hit_ctrl | (paddr_in == `MODE_OFFSET);

reg [31:0] read_mux;
always @* begin
    read_mux = 32'h0000_0000;
    case (paddr_in)
        `STATUS_OFFSET: begin
            read_mux[`ST_COLD_START_BIT] = cold_start_flag;
            read_mux[`ST_WAKE_REQUEST_BIT] = wake_request_flag;
            read_mux[`ST_WAKE_SRC_VALID_BIT] = wake_source_flag;
            read_mux[`ST_WAKE_SRC_LOCAL_BIT] = wake_src_local_reg;
            read_mux[`ST_MASK_CHANGE_BIT] = mask_change_flag;
            read_mux[`ST_MASK_LATCHED_BIT] = mask_latched_reg;
            read_mux[`ST_CORE_LOW_BIT] = core_supply_low_flag;
            read_mux[`ST_FAULT_N_BIT] = fault_indicator_n;
        end
        `CTRL_OFFSET: begin
            read_mux[`CTRL_WIDTH-1:0] = mask_limit_reg;
        end
        `MODE_OFFSET: begin
            read_mux[4:0] = mode_reg;
        end
        default: begin
            read_mux = 32'h0000_0000;
        end
    endcase
end

// Registered answer keeps every bus output straight from a flop
always @(posedge clock_in) begin
    if (rst_in) begin
        pready_out <= 1'b0;
        pslverr_out <= 1'b0;
        prdata_out <= 32'h0000_0000;
        mask_limit_reg <= MASK_LIMIT_RST;
    end else begin
        pready_out <= apb_setup;
        pslverr_out <= apb_setup & ~hit_any;
        prdata_out <= (apb_setup & ~pwrite_in) ? read_mux : 32'h0000_0000;
        if (apb_write & hit_ctrl) begin
            mask_limit_reg <= pwdata_in[`CTRL_WIDTH-1:0];
        end
    end
end

endmodule

// ---- hdl/uv_filter.v ----
// Persistence timer for a supply undervoltage level
`timescale 1ns/1ps
module uv_filter #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] LIMIT = 16'h1D4C
) (
    // Clock and reset
    input wire clock_in,
    input wire rst_in,
    // Monitor level and timer restart
    input wire low_in,
    input wire restart_in,
    // Undervoltage has persisted
    output reg expired_out
);

reg [WIDTH-1:0] count_reg;

// Timer runs only while the supply stays low
always @(posedge clock_in) begin
    if (rst_in || !low_in || restart_in) begin
        count_reg <= {WIDTH{1'b0}};
        expired_out <= 1'b0;
    end else if (count_reg < LIMIT) begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        expired_out <= 1'b0;
    end else begin
        expired_out <= 1'b1;
    end
end

endmodule

// ---- shared/status_mask_regs.vh ----
// Constants for the transceiver status flags and power-enable mask block
`ifndef STATUS_MASK_REGS_VH
`define STATUS_MASK_REGS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define MASK_FILTER_TIME_NS 10000
`define MASK_FILTER_CYCLES ((`MASK_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_FILTER_TIME_NS 30000
`define UV_FILTER_CYCLES ((`UV_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TXD_EDGES_TO_CLEAR 3'h4

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define STATUS_OFFSET 12'h000
`define CTRL_OFFSET 12'h004
`define MODE_OFFSET 12'h008

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_COLD_START_BIT 0
`define ST_WAKE_REQUEST_BIT 1
`define ST_WAKE_SRC_VALID_BIT 2
`define ST_WAKE_SRC_LOCAL_BIT 3
`define ST_MASK_CHANGE_BIT 4
`define ST_MASK_LATCHED_BIT 5
`define ST_CORE_LOW_BIT 6
`define ST_FAULT_N_BIT 7

// ----------------------------------------------------------------
// Control register: mask filter length in cycles
// ----------------------------------------------------------------
`define CTRL_WIDTH 16

// ----------------------------------------------------------------
// Mode codes, one-hot
// ----------------------------------------------------------------
`define MODE_NORMAL 5'h01
`define MODE_SILENT 5'h02
`define MODE_STANDBY 5'h04
`define MODE_GO_SLEEP 5'h08
`define MODE_SLEEP 5'h10
`define MODE_RESET `MODE_STANDBY

`endif
